// ---- src/ext_regs_params.svh ----
// register offsets, field positions, reset values and timing for the extended register bank
`ifndef EXT_REGS_PARAMS_SVH
`define EXT_REGS_PARAMS_SVH

`define OFS_PWR_CTRL 5'h14
`define OFS_ADDR_POE 5'h17
`define OFS_FAULTS 5'h1c

`define PC_NO_CEXT 15
`define PC_SLEEP_HI 14
`define PC_SLEEP_LO 13
`define PC_WAKE_HI 12
`define PC_WAKE_LO 11
`define PC_ADDR_REV 9
`define PC_CLKSEL 8
`define PC_MEDIA_HI 7
`define PC_MEDIA_LO 6
`define PC_NOPRE 5
`define PC_DSH_EN 4
`define PC_DSH_CNT_HI 3
`define PC_DSH_CNT_LO 2
`define PC_DSH_STAT 1

`define AP_ADDR_HI 15
`define AP_ADDR_LO 11
`define AP_DET_EN 10
`define AP_DET_HI 9
`define AP_DET_LO 8
`define AP_CRC_HI 7
`define AP_CRC_LO 0

`define FL_MAC_LO 8
`define FL_MED_LO 0

`define RST_SLEEP 2'h1
`define RST_WAKE 2'h3
`define RST_DSH_CNT 2'h1
`define RST_CLKSEL 1'h0
`define CRC_MAX 8'hff

`define CLK_HZ 10000000
`define SLEEP_UNIT_S 1
`define WAKE_160_MS 160
`define WAKE_400_MS 400
`define WAKE_800_MS 800
`define WAKE_2000_MS 2000
`define SLEEP_UNIT_CYC (`SLEEP_UNIT_S * `CLK_HZ)
`define MS_CYC(ms) ((ms) * (`CLK_HZ / 1000))

`endif

// ---- src/ext_regs_pkg.sv ----
// types shared by the extended register bank
package ext_regs_pkg;

	typedef enum logic [1:0] {
		media_none = 2'h0,
		media_copper = 2'h1,
		media_serdes = 2'h2
	} media_t;

	typedef enum logic [1:0] {
		poe_searching = 2'h0,
		poe_needs_power = 2'h1,
		poe_no_power = 2'h2
	} poe_det_t;

	// register bus request
	typedef struct packed {
		logic [4:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	// events from one serdes receiver, in flag bit order 3..0
	typedef struct packed {
		logic sync_loss;
		logic cg_bad;
		logic realign;
		logic pll_unlock;
	} serdes_evt_t;

	// settings driven to the phy datapaths
	typedef struct packed {
		logic no_carrier_ext;
		logic addr_reverse;
		logic clk_156;
		logic nopre_10;
		logic dshift_en;
		logic [1:0] dshift_tries;
		logic poe_det_en;
	} phy_cfg_t;

endpackage : ext_regs_pkg

// ---- src/ext_regs.sv ----
// extended power-save, address/inline-power and serdes fault register bank
`timescale 1ns/1ps
`include "ext_regs_params.svh"

// Functional notes
// - bits 14:13 pick sleep timeout 1 to 4 seconds, reset 01
// - bits 12:11 pick wake interval 160/400/800 ms or 2 s, reset 11
// - bit 15 disables carrier extension and moves sgmii mac to v1.8 level
// - bit 9 reverses phy address assignment, reset value from strap pins
// - bit 8 picks clock output 156.25 MHz or 125 MHz, cleared by reset
// - clock output select acts only in the first port instance
// - bits 7:6 read the active medium: none, copper, serdes
// - bit 5 lets 10BASE-T assert receive valid without preamble
// - bit 4 enables gigabit auto downshift, reset value from strap pins
// - bits 3:2 set failed attempts before downshift: two to five
// - bit 1 reads one when downshift required or done, reset zero
// - second register bits 15:11 return strap-captured management address
// - bit 10 enables inline power detection; status valid only when enabled
// - detection status: searching, needs power, no power needed
// - bits 7:0 count generator crc errors, saturate, clear on read
// - fault bit 11 latches mac side loss of sync, clears on read
// - fault bit 3 latches media side loss of sync, clears on read
// - fault bits 10 and 2 latch cgbad per side, clear on read
// - fault bits 9 and 1 latch comma realignment, clear on read
// - fault bits 8 and 0 latch receive pll lock loss, clear on read
module ext_regs #(
	parameter bit FIRST_PORT = 1'b1,
	parameter int SLEEP_UNIT_CYCLES = `SLEEP_UNIT_CYC,
	parameter int WAKE_160_CYCLES = `MS_CYC(`WAKE_160_MS),
	parameter int WAKE_400_CYCLES = `MS_CYC(`WAKE_400_MS),
	parameter int WAKE_800_CYCLES = `MS_CYC(`WAKE_800_MS),
	parameter int WAKE_2000_CYCLES = `MS_CYC(`WAKE_2000_MS)
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire ext_regs_pkg::reg_req_t req,
	output logic [15:0] rdata,
	input wire logic [4:0] strap_phy_addr,
	input wire logic strap_addr_rev,
	input wire logic strap_dshift_en,
	input wire ext_regs_pkg::media_t media_mode,
	input wire logic dshift_event,
	input wire ext_regs_pkg::poe_det_t poe_status,
	input wire logic crc_err,
	input wire ext_regs_pkg::serdes_evt_t mac_evt,
	input wire ext_regs_pkg::serdes_evt_t media_evt,
	output ext_regs_pkg::phy_cfg_t cfg,
	output logic [31:0] sleep_cycles,
	output logic [31:0] wake_cycles
);
	import ext_regs_pkg::*;

	logic [1:0] sleep_sel_r;
	logic [1:0] wake_sel_r;
	logic no_cext_r;
	logic addr_rev_r;
	logic clk_sel_r;
	logic nopre_r;
	logic dshift_en_r;
	logic [1:0] dshift_cnt_r;
	logic dshift_stat_r;
	logic poe_en_r;
	logic [4:0] phy_addr_r;
	logic [7:0] crc_cnt_r;
	logic [3:0] mac_flags_r;
	logic [3:0] med_flags_r;
	logic [4:0] strap_addr_s1_r;
	logic [4:0] strap_addr_s2_r;
	logic [1:0] strap_bits_s1_r;
	logic [1:0] strap_bits_s2_r;
	logic [1:0] media_s1_r;
	logic [1:0] media_s2_r;
	logic [1:0] poe_s1_r;
	logic [1:0] poe_s2_r;
	logic strap_pending_r;
	logic wr_pc;
	logic wr_ap;
	logic rd_ap;
	logic rd_fl;
	logic [15:0] pc_word;
	logic [15:0] ap_word;
	logic [15:0] fl_word;

	// address match shared by the write and read decode
	function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	// request decode; a control write on the strap-load edge is dropped, straps win
	assign wr_pc = req.wr && !strap_pending_r && hit(req.addr, `OFS_PWR_CTRL);
	assign wr_ap = req.wr && hit(req.addr, `OFS_ADDR_POE);
	assign rd_ap = req.rd && hit(req.addr, `OFS_ADDR_POE);
	assign rd_fl = req.rd && hit(req.addr, `OFS_FAULTS);

	// straps and status levels come from other domains: two flops before use
	always_ff @(posedge sys_clk)
	begin
		strap_addr_s1_r <= strap_phy_addr;
		strap_addr_s2_r <= strap_addr_s1_r;
		strap_bits_s1_r <= {strap_addr_rev, strap_dshift_en};
		strap_bits_s2_r <= strap_bits_s1_r;
		media_s1_r <= media_mode;
		media_s2_r <= media_s1_r;
		poe_s1_r <= poe_status;
		poe_s2_r <= poe_s1_r;
	end

	// strap load flag: set in reset, so capture happens on the first edge after reset is released
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			strap_pending_r <= 1'b1;
		else
			strap_pending_r <= 1'b0;
	end

	// management address latched from straps once per reset
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			phy_addr_r <= 5'h00;
		else if (strap_pending_r)
			phy_addr_r <= strap_addr_s2_r;
	end

	// carrier extension switch
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			no_cext_r <= 1'b0;
		else if (wr_pc)
			no_cext_r <= req.wdata[`PC_NO_CEXT];
	end

	// sleep timer select
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			sleep_sel_r <= `RST_SLEEP;
		else if (wr_pc)
			sleep_sel_r <= req.wdata[`PC_SLEEP_HI:`PC_SLEEP_LO];
	end

	// wake timer select
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			wake_sel_r <= `RST_WAKE;
		else if (wr_pc)
			wake_sel_r <= req.wdata[`PC_WAKE_HI:`PC_WAKE_LO];
	end

	// clock output select; kept in both ports, only the first one uses it
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			clk_sel_r <= `RST_CLKSEL;
		else if (wr_pc)
			clk_sel_r <= req.wdata[`PC_CLKSEL];
	end

	// 10BASE-T receive without preamble
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			nopre_r <= 1'b0;
		else if (wr_pc)
			nopre_r <= req.wdata[`PC_NOPRE];
	end

	// failed gigabit attempts before a downshift
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			dshift_cnt_r <= `RST_DSH_CNT;
		else if (wr_pc)
			dshift_cnt_r <= req.wdata[`PC_DSH_CNT_HI:`PC_DSH_CNT_LO];
	end

	// address reversal: strap value on the load edge, software after that
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			addr_rev_r <= 1'b0;
		else if (strap_pending_r)
			addr_rev_r <= strap_bits_s2_r[1];
		else if (wr_pc)
			addr_rev_r <= req.wdata[`PC_ADDR_REV];
	end

	// downshift enable: strap value on the load edge, software after that
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			dshift_en_r <= 1'b0;
		else if (strap_pending_r)
			dshift_en_r <= strap_bits_s2_r[0];
		else if (wr_pc)
			dshift_en_r <= req.wdata[`PC_DSH_EN];
	end

	// downshift status holds once the copper side reports it while downshift is enabled
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			dshift_stat_r <= 1'b0;
		else if (dshift_event && dshift_en_r)
			dshift_stat_r <= 1'b1;
	end

	// inline power detection enable
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			poe_en_r <= 1'b0;
		else if (wr_ap)
			poe_en_r <= req.wdata[`AP_DET_EN];
	end

	// crc error counter: saturates; an error in the clearing read starts at one
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			crc_cnt_r <= 8'h00;
		else if (rd_ap)
			crc_cnt_r <= {7'h00, crc_err};
		else if (crc_err && crc_cnt_r != `CRC_MAX)
			crc_cnt_r <= crc_cnt_r + 8'h01;
	end

	// sticky fault flags, one flop per bit; set wins so no event is lost to a read
	for (genvar g = 0; g < 4; g++)
	begin : g_flag
		always_ff @(posedge sys_clk)
		begin
			if (srst)
			begin
				mac_flags_r[g] <= 1'b0;
				med_flags_r[g] <= 1'b0;
			end
			else
			begin
				mac_flags_r[g] <= (mac_flags_r[g] && !rd_fl) || mac_evt[g];
				med_flags_r[g] <= (med_flags_r[g] && !rd_fl) || media_evt[g];
			end
		end
	end

	// assembled read words; reserved bits read zero
	always_comb
	begin
		pc_word = 16'h0000;
		pc_word[`PC_NO_CEXT] = no_cext_r;
		pc_word[`PC_SLEEP_HI:`PC_SLEEP_LO] = sleep_sel_r;
		pc_word[`PC_WAKE_HI:`PC_WAKE_LO] = wake_sel_r;
		pc_word[`PC_ADDR_REV] = addr_rev_r;
		pc_word[`PC_CLKSEL] = clk_sel_r;
		pc_word[`PC_MEDIA_HI:`PC_MEDIA_LO] = media_s2_r;
		pc_word[`PC_NOPRE] = nopre_r;
		pc_word[`PC_DSH_EN] = dshift_en_r;
		pc_word[`PC_DSH_CNT_HI:`PC_DSH_CNT_LO] = dshift_cnt_r;
		pc_word[`PC_DSH_STAT] = dshift_stat_r;
		ap_word = 16'h0000;
		ap_word[`AP_ADDR_HI:`AP_ADDR_LO] = phy_addr_r;
		ap_word[`AP_DET_EN] = poe_en_r;
		// status is forced to searching while detection is off
		ap_word[`AP_DET_HI:`AP_DET_LO] = poe_en_r ? poe_s2_r : poe_searching;
		ap_word[`AP_CRC_HI:`AP_CRC_LO] = crc_cnt_r;
		fl_word = 16'h0000;
		fl_word[`FL_MAC_LO+3:`FL_MAC_LO] = mac_flags_r;
		fl_word[`FL_MED_LO+3:`FL_MED_LO] = med_flags_r;
	end

	// read data valid the cycle after the strobe only; unmapped reads give zero
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			rdata <= 16'h0000;
		else if (req.rd)
		begin
			if (hit(req.addr, `OFS_PWR_CTRL))
				rdata <= pc_word;
			else if (hit(req.addr, `OFS_ADDR_POE))
				rdata <= ap_word;
			else if (hit(req.addr, `OFS_FAULTS))
				rdata <= fl_word;
			else
				rdata <= 16'h0000;
		end
		else
			rdata <= 16'h0000;
	end

	// settings to the datapaths, registered so outputs come from flops
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			cfg.no_carrier_ext <= 1'b0;
		else
			cfg.no_carrier_ext <= no_cext_r;
	end

	// address reversal setting
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			cfg.addr_reverse <= 1'b0;
		else
			cfg.addr_reverse <= addr_rev_r;
	end

	// clock output select; a second port never drives the pin, so it stays low
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			cfg.clk_156 <= 1'b0;
		else
			cfg.clk_156 <= FIRST_PORT ? clk_sel_r : 1'b0;
	end

	// no-preamble receive setting
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			cfg.nopre_10 <= 1'b0;
		else
			cfg.nopre_10 <= nopre_r;
	end

	// downshift enable setting
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			cfg.dshift_en <= 1'b0;
		else
			cfg.dshift_en <= dshift_en_r;
	end

	// downshift attempt count setting
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			cfg.dshift_tries <= 2'h0;
		else
			cfg.dshift_tries <= dshift_cnt_r;
	end

	// inline power detection setting
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			cfg.poe_det_en <= 1'b0;
		else
			cfg.poe_det_en <= poe_en_r;
	end

	// sleep timer length in sys_clk cycles; zero only while in reset
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			sleep_cycles <= 32'h0;
		else
			sleep_cycles <= 32'(SLEEP_UNIT_CYCLES) * (32'(sleep_sel_r) + 32'h1);
	end

	// wake interval length in sys_clk cycles
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			wake_cycles <= 32'h0;
		else
			unique case (wake_sel_r)
				2'h0: wake_cycles <= 32'(WAKE_160_CYCLES);
				2'h1: wake_cycles <= 32'(WAKE_400_CYCLES);
				2'h2: wake_cycles <= 32'(WAKE_800_CYCLES);
				2'h3: wake_cycles <= 32'(WAKE_2000_CYCLES);
			endcase
	end

endmodule : ext_regs

// ---- sim/ext_regs_sva.sv ----
// port assertions for the extended register bank
`timescale 1ns/1ps
module ext_regs_sva #(
	parameter bit FIRST_PORT = 1'b1,
	parameter int SLEEP_UNIT_CYCLES = 10
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire ext_regs_pkg::reg_req_t req,
	input wire logic [15:0] rdata,
	input wire ext_regs_pkg::serdes_evt_t mac_evt,
	input wire ext_regs_pkg::serdes_evt_t media_evt,
	input wire ext_regs_pkg::phy_cfg_t cfg,
	input wire logic [31:0] sleep_cycles
);
	import ext_regs_pkg::*;
	logic rd_pc, rd_ap, rd_fl, wr_pc, quiet;
	logic [15:0] evt_all;
	// decoded requests keep the properties short
	assign rd_pc = req.rd && req.addr == 5'h14;
	assign rd_ap = req.rd && req.addr == 5'h17;
	assign rd_fl = req.rd && req.addr == 5'h1c;
	assign wr_pc = req.wr && req.addr == 5'h14;
	assign quiet = mac_evt == 4'h0 && media_evt == 4'h0;
	assign evt_all = {4'h0, mac_evt, 4'h0, media_evt};
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);
	a_idle_rdata_zero: assert property (!req.rd |=> rdata == 16'h0)
		else $error("read data not zero outside a read");
	a_unmapped_zero: assert property (req.rd && !(rd_pc || rd_ap || rd_fl) |=> rdata == 16'h0)
		else $error("unmapped read not zero");
	a_fault_reserved: assert property (rd_fl |=> rdata[15:12] == 4'h0 && rdata[7:4] == 4'h0)
		else $error("reserved fault bits set");
	a_flag_latch: assert property (!quiet && !req.rd ##1 rd_fl |=>
		(rdata & $past(evt_all, 2)) == $past(evt_all, 2)) else $error("event flag not latched");
	a_flag_clear: assert property (rd_fl && quiet ##1 rd_fl && quiet |=> rdata == 16'h0)
		else $error("flag survived its read");
	a_poe_masked: assert property (rd_ap ##1 !rdata[10] |-> rdata[9:8] == 2'h0)
		else $error("detection status shown while disabled");
	a_cfg_write: assert property (wr_pc |-> ##2 cfg.no_carrier_ext == $past(req.wdata[15], 2)
		&& cfg.nopre_10 == $past(req.wdata[5], 2) && cfg.dshift_tries == $past(req.wdata[3:2], 2))
		else $error("settings do not follow write");
	a_clk_port: assert property (wr_pc |-> ##2 cfg.clk_156 == (FIRST_PORT && $past(req.wdata[8], 2)))
		else $error("clock output select wrong");
	a_sleep_legal: assert property (!$past(srst) |-> sleep_cycles inside {32'(SLEEP_UNIT_CYCLES),
		32'(2 * SLEEP_UNIT_CYCLES), 32'(3 * SLEEP_UNIT_CYCLES), 32'(4 * SLEEP_UNIT_CYCLES)})
		else $error("sleep length not one to four units");
	c_write: cover property (wr_pc);
	c_flag_twice: cover property (rd_fl ##1 rd_fl);
	c_poe_on: cover property (rd_ap ##1 rdata[10]);
endmodule : ext_regs_sva
bind ext_regs ext_regs_sva #(.FIRST_PORT(FIRST_PORT), .SLEEP_UNIT_CYCLES(SLEEP_UNIT_CYCLES)) ext_regs_sva_i (
	.sys_clk(sys_clk), .srst(srst), .req(req), .rdata(rdata), .mac_evt(mac_evt),
	.media_evt(media_evt), .cfg(cfg), .sleep_cycles(sleep_cycles));

// ---- sim/ext_regs_bench.sv ----
// self-checking bench for the extended register bank
`timescale 1ns/1ps
`include "ext_regs_params.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
	$display("wrong value at %0t: got %h want %h", $time, (a), (e)); end end
module ext_regs_bench;
	import ext_regs_pkg::*;
	localparam int SU = 10;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	reg_req_t req = '0;
	logic [15:0] rdata;
	logic [4:0] strap_phy_addr = 5'h15;
	logic strap_addr_rev = 1'b1;
	logic strap_dshift_en = 1'b1;
	media_t media_mode = media_copper;
	logic dshift_event = 1'b0;
	poe_det_t poe_status = poe_needs_power;
	logic crc_err = 1'b0;
	serdes_evt_t mac_evt = '0;
	serdes_evt_t media_evt = '0;
	phy_cfg_t cfg;
	logic [31:0] sleep_cycles, wake_cycles;
	logic [1:0] k;
	int fails = 0;
	int n_checks = 0;
	int wake_tab [4] = '{16, 40, 80, 200};
	ext_regs #(.SLEEP_UNIT_CYCLES(SU), .WAKE_160_CYCLES(16), .WAKE_400_CYCLES(40),
		.WAKE_800_CYCLES(80), .WAKE_2000_CYCLES(200)) ext_regs_i (.sys_clk(sys_clk), .srst(srst),
		.req(req), .rdata(rdata), .strap_phy_addr(strap_phy_addr), .strap_addr_rev(strap_addr_rev),
		.strap_dshift_en(strap_dshift_en), .media_mode(media_mode), .dshift_event(dshift_event),
		.poe_status(poe_status), .crc_err(crc_err), .mac_evt(mac_evt), .media_evt(media_evt),
		.cfg(cfg), .sleep_cycles(sleep_cycles), .wake_cycles(wake_cycles));
	// 100 ns period
	always #50 sys_clk = ~sys_clk;
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		req.wr <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		req.rd <= 1'b0;
		#1 `CHK(rdata, e)
	endtask : rd
	// pulses spaced one idle cycle apart
	task automatic crc(input int n);
		repeat (n)
		begin
			@(posedge sys_clk);
			crc_err <= 1'b1;
			@(posedge sys_clk);
			crc_err <= 1'b0;
		end
	endtask : crc
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	// hang guard, far beyond the fewer than a thousand cycles the tests need
	initial
	begin
		#(10000 * 100);
		fails++;
		wrap_up();
	end
	initial
	begin
		repeat (3) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		rd(`OFS_PWR_CTRL, 16'h3a54);
		rd(`OFS_ADDR_POE, 16'ha800);
		rd(`OFS_FAULTS, 16'h0);
		`CHK(wake_cycles, 32'(200))
		wr(`OFS_PWR_CTRL, 16'hffff);
		rd(`OFS_PWR_CTRL, 16'hfb7c);
		`CHK(cfg, 8'hfe)
		for (int i = 0; i < 4; i++)
		begin
			k = 2'(i);
			wr(`OFS_PWR_CTRL, {1'b0, k, k, 7'h0, k, 2'h0});
			repeat (3) @(posedge sys_clk);
			#1 `CHK(sleep_cycles, 32'((i + 1) * SU))
			`CHK(wake_cycles, 32'(wake_tab[i]))
			`CHK(cfg.dshift_tries, k)
		end
		for (int i = 0; i < 3; i++)
		begin
			@(posedge sys_clk);
			media_mode <= media_t'(i);
			repeat (4) @(posedge sys_clk);
			rd(`OFS_PWR_CTRL, 16'h780c | (16'(i) << 6));
		end
		@(posedge sys_clk);
		dshift_event <= 1'b1;
		rd(`OFS_PWR_CTRL, 16'h788c);
		wr(`OFS_PWR_CTRL, 16'h781c);
		rd(`OFS_PWR_CTRL, 16'h789e);
		@(posedge sys_clk);
		dshift_event <= 1'b0;
		rd(`OFS_PWR_CTRL, 16'h789e);
		wr(`OFS_ADDR_POE, 16'hffff);
		for (int i = 0; i < 3; i++)
		begin
			@(posedge sys_clk);
			poe_status <= poe_det_t'(i);
			repeat (4) @(posedge sys_clk);
			rd(`OFS_ADDR_POE, 16'hac00 | (16'(i) << 8));
		end
		`CHK(cfg.poe_det_en, 1'b1)
		wr(`OFS_ADDR_POE, 16'h0);
		rd(`OFS_ADDR_POE, 16'ha800);
		`CHK(cfg.poe_det_en, 1'b0)
		crc(3);
		rd(`OFS_ADDR_POE, 16'ha803);
		rd(`OFS_ADDR_POE, 16'ha800);
		crc(300);
		fork
			rd(`OFS_ADDR_POE, 16'ha8ff);
			crc(1);
		join
		rd(`OFS_ADDR_POE, 16'ha801);
		wr(`OFS_FAULTS, 16'hffff);
		wr(5'h03, 16'hffff);
		rd(5'h03, 16'h0);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge sys_clk);
			mac_evt <= serdes_evt_t'(4'(1 << i));
			media_evt <= serdes_evt_t'(4'(8 >> i));
			@(posedge sys_clk);
			mac_evt <= '0;
			media_evt <= '0;
			req <= '{addr: `OFS_FAULTS, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
			@(posedge sys_clk);
			#1 `CHK(rdata, 16'((16'h100 << i) | (16'h8 >> i)))
			@(posedge sys_clk);
			req.rd <= 1'b0;
			#1 `CHK(rdata, 16'h0)
		end
		// a second reset in mid-run must restore the defaults
		@(posedge sys_clk);
		srst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		rd(`OFS_PWR_CTRL, 16'h3a94);
		rd(`OFS_ADDR_POE, 16'ha800);
		wrap_up();
	end
endmodule : ext_regs_bench
